// ==== common/sas_pkg.sv ====
// constants and types for the converter sequencer
// Behaviour
// RULE1: one of 16 analog sources is routed, chosen by the 4-bit channel field.
// RULE2: each conversion is eight compare steps, msb first, one bit each.
// RULE3: a finished approximation is copied to the result slot the position picks.
// RULE4: options bit 7 powers the converter and charge pump; zero disables both.
// RULE5: software waits up to 100 us bias settling after power-up.
// RULE6: four readable 8-bit result registers, numbered one to four.
// RULE7: result updates never collide with processor reads of results.
// RULE8: clock select bit: zero uses system clock, one uses the rc oscillator.
// RULE9: software picks the rc oscillator when the system clock is below 750 kHz.
// RULE10: conversions run in groups of four, once or continuously.
// RULE11: done flag sets once the fourth conversion of a group is stored.
// RULE12: a group starts one cycle after any control/status write.
// RULE13: low reference gives 00, high gives ff, above full scale saturates silently.
// RULE14: codes 0-7 ports, 12-14 references; multi mode low bits pick the slot.
// RULE15: single one-pass converts one channel four times into slots one to four.
// RULE16: single continuous keeps converting, wrapping the slot position.
// RULE17: sample switch closes only in a 12-cycle window at conversion start.
// RULE18: software avoids digital reads of analog pins during sampling.
// RULE19: write-once option bits: one write in first 64 cycles, any time special.
// RULE20: stop exit waits about 4000 cycles with delay bit set, else four.
// RULE21: control/status selects once/continuous, single/multi, and reports status.
// RULE22: every control/status write clears done and restarts, abandoning the group.
// RULE23: multi clear converts one channel; set gives one channel per slot.
// RULE24: in multi mode only the upper two select bits pick the group.
// RULE25: control/status bit 7 is read-only done, bit 6 reads zero.
// RULE26: a 2-bit position counter picks the slot, zeroed at start, wrapping.
// RULE27: continuous mode keeps done set until a control/status write.
package sas_pkg;
   // register byte addresses
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] RES1_OFS   = 8'h04;
   localparam logic [7:0] RES4_OFS   = 8'h10;
   localparam logic [7:0] OPT_OFS    = 8'h14;
   // control/status fields
   localparam int         DONE_BIT   = 7;
   localparam int         CONT_BIT   = 5;
   localparam int         MULTI_BIT  = 4;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   // options fields
   localparam int         PWR_BIT    = 7;
   localparam int         CONV_CLOCK_SELECT_BIT   = 6;
   localparam int         DLY_BIT    = 4;
   localparam logic [7:0] OPT_ONCE   = 8'h33;
   localparam logic [7:0] OPT_FREE   = 8'hc8;
   localparam logic [7:0] OPT_RST    = 8'h00;
   // timing
   localparam int         CLK_KHZ    = 25000;
   localparam int         BIAS_US    = 100;
   localparam int         BIAS_CYC   = BIAS_US * CLK_KHZ / 1000;
   localparam logic [3:0] SAMPLE_CYC = 4'hc;
   localparam logic [3:0] STEP_CYC   = 4'h3;
   localparam logic [6:0] ONCE_CYC   = 7'h40;
   localparam logic [11:0] STOP_LONG = 12'hfa0;
   localparam logic [11:0] STOP_SHORT = 12'h004;

   typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_STEP, SAS_STORE} sas_state_t;

   typedef struct packed {
      logic [15:0] source;
      logic        sample;
      logic [7:0]  trial;
      logic        pump;
      logic        clk_sel;
   } sas_afe_t;
endpackage

// ==== core/sas_core.sv ====
// converter sequencer with apb registers
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
module sas_core (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          comp_in,
   input  wire logic          rc_tick,
   input  wire logic          stop_in,
   input  wire logic          special_mode,
   output sas_pkg::sas_afe_t  afe,
   output logic               resume_ready
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [1:0] comp_s_q, rc_s_q, stop_s_q, spec_s_q;
   logic       rc_old_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         comp_s_q <= 2'h0;
         rc_s_q   <= 2'h0;
         stop_s_q <= 2'h0;
         spec_s_q <= 2'h0;
         rc_old_q <= 1'b0;
      end else if (ce) begin
         comp_s_q <= {comp_s_q[0], comp_in};
         rc_s_q   <= {rc_s_q[0], rc_tick};
         stop_s_q <= {stop_s_q[0], stop_in};
         spec_s_q <= {spec_s_q[0], special_mode};
         rc_old_q <= rc_s_q[1];
      end
   end

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   logic [7:0]  ctrl_q, opt_q;
   logic [7:0]  res_q [4];
   logic        done_q, once_used_q, pready_q, pslverr_q;
   logic [6:0]  age_q;
   logic [31:0] prdata_q;
   logic        acc, wr, rd, ctrl_wr, opt_wr, once_ok, mapped;
   logic [7:0]  rd_val;

   assign acc     = psel & penable & pready_q;
   assign wr      = acc & pwrite;
   assign rd      = psel & penable & !pwrite;
   assign ctrl_wr = wr & (paddr == sas_pkg::CTRL_OFS);
   assign opt_wr  = wr & (paddr == sas_pkg::OPT_OFS);
   assign once_ok = spec_s_q[1] | (!once_used_q & (age_q < sas_pkg::ONCE_CYC)); // RULE19
   assign mapped  = (paddr[1:0] == 2'h0) & (paddr <= sas_pkg::OPT_OFS);

   always_comb begin
      rd_val = 8'h00;
      if (paddr == sas_pkg::CTRL_OFS)
         rd_val = {done_q, 1'b0, ctrl_q[5:0]}; // RULE25 RULE21
      else if (paddr == sas_pkg::OPT_OFS)
         rd_val = {opt_q[7:3], 1'b0, opt_q[1:0]};
      else if (paddr >= sas_pkg::RES1_OFS && paddr <= sas_pkg::RES4_OFS)
         rd_val = res_q[2'(paddr[4:2] - 3'h1)]; // RULE6
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else if (ce) begin
         pready_q  <= psel & penable & !pready_q;
         pslverr_q <= psel & penable & !pready_q & !mapped;
         if (psel & penable & !pready_q)
            prdata_q <= {24'h0, rd_val};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= sas_pkg::CTRL_RST;
      end else if (ce && ctrl_wr) begin
         ctrl_q <= pwdata[7:0] & sas_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         opt_q       <= sas_pkg::OPT_RST;
         once_used_q <= 1'b0;
         age_q       <= 7'h0;
      end else if (ce) begin
         if (age_q < sas_pkg::ONCE_CYC)
            age_q <= age_q + 7'h1;
         if (opt_wr) begin
            opt_q <= (pwdata[7:0] & sas_pkg::OPT_FREE)
                   | ((once_ok ? pwdata[7:0] : opt_q) & sas_pkg::OPT_ONCE); // RULE19
            if (once_ok)
               once_used_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // stop exit delay
   // ------------------------------------------------------------
   logic [11:0] exit_q;
   logic        stopped_q, suspend;
   // stopped_q bridges the cycle before the exit count loads
   assign suspend = stop_s_q[1] | stopped_q | (exit_q != 12'h0); // RULE20
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exit_q    <= 12'h0;
         stopped_q <= 1'b0;
      end else if (ce) begin
         stopped_q <= stop_s_q[1];
         if (stopped_q & !stop_s_q[1])
            exit_q <= opt_q[sas_pkg::DLY_BIT] ? sas_pkg::STOP_LONG : sas_pkg::STOP_SHORT; // RULE20
         else if (exit_q != 12'h0)
            exit_q <= exit_q - 12'h1;
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   sas_pkg::sas_state_t state_q;
   logic [3:0] cyc_q, chan;
   logic [2:0] bit_q;
   logic [1:0] pos_q;
   logic [7:0] sar_q;
   logic       pwr, tick, rd_hit, last;

   assign pwr    = opt_q[sas_pkg::PWR_BIT]; // RULE4
   assign tick   = opt_q[sas_pkg::CONV_CLOCK_SELECT_BIT] ? (rc_s_q[1] & !rc_old_q) : 1'b1; // RULE8
   assign chan   = ctrl_q[sas_pkg::MULTI_BIT] ? {ctrl_q[3:2], pos_q} : ctrl_q[3:0]; // RULE23 RULE24 RULE14
   assign rd_hit = rd & (paddr >= sas_pkg::RES1_OFS) & (paddr <= sas_pkg::RES4_OFS);
   assign last   = (pos_q == 2'h3);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= sas_pkg::SAS_IDLE;
         cyc_q   <= 4'h0;
         bit_q   <= 3'h7;
         pos_q   <= 2'h0;
         sar_q   <= 8'h00;
      end else if (ce) begin
         if (ctrl_wr) begin
            state_q <= sas_pkg::SAS_SAMPLE; // RULE12 RULE22
            cyc_q   <= 4'h0;
            bit_q   <= 3'h7;
            pos_q   <= 2'h0; // RULE26
            sar_q   <= 8'h00;
         end else if (!pwr) begin
            state_q <= sas_pkg::SAS_IDLE;
         end else if (suspend) begin
            if (state_q != sas_pkg::SAS_IDLE) begin
               state_q <= sas_pkg::SAS_SAMPLE; // resample current channel
               cyc_q   <= 4'h0;
               bit_q   <= 3'h7;
               sar_q   <= 8'h00;
            end
         end else if (tick) begin
            unique case (state_q)
               sas_pkg::SAS_IDLE: begin
               end
               sas_pkg::SAS_SAMPLE: begin
                  if (cyc_q == sas_pkg::SAMPLE_CYC - 4'h1) begin // RULE17
                     state_q <= sas_pkg::SAS_STEP;
                     cyc_q   <= 4'h0;
                     sar_q   <= 8'h80; // RULE2
                  end else begin
                     cyc_q <= cyc_q + 4'h1;
                  end
               end
               sas_pkg::SAS_STEP: begin
                  if (cyc_q == sas_pkg::STEP_CYC) begin
                     cyc_q <= 4'h0;
                     // comparator high keeps the trial bit; saturates at ff
                     sar_q[bit_q] <= comp_s_q[1]; // RULE2 RULE13
                     if (bit_q == 3'h0)
                        state_q <= sas_pkg::SAS_STORE;
                     else begin
                        bit_q <= bit_q - 3'h1;
                        sar_q[3'(bit_q - 3'h1)] <= 1'b1;
                     end
                  end else begin
                     cyc_q <= cyc_q + 4'h1;
                  end
               end
               sas_pkg::SAS_STORE: begin
                  if (!rd_hit) begin // RULE7
                     pos_q <= pos_q + 2'h1; // RULE26 RULE16
                     bit_q <= 3'h7;
                     sar_q <= 8'h00;
                     cyc_q <= 4'h0;
                     if (last & !ctrl_q[sas_pkg::CONT_BIT])
                        state_q <= sas_pkg::SAS_IDLE; // RULE15 RULE10
                     else
                        state_q <= sas_pkg::SAS_SAMPLE; // RULE10
                  end
               end
            endcase
         end
      end
   end

   logic store;
   assign store = ce & pwr & !suspend & !ctrl_wr & tick & !rd_hit
                & (state_q == sas_pkg::SAS_STORE);

   // ------------------------------------------------------------
   // result slots and done flag
   // ------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_res
      always_ff @(posedge clk) begin
         if (!rst_n)
            res_q[i] <= 8'h00;
         else if (store && pos_q == 2'(i))
            res_q[i] <= sar_q; // RULE3
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         done_q <= 1'b0;
      else if (ce)
         done_q <= (store & last) | (done_q & !ctrl_wr); // RULE11 RULE22 RULE27
   end

   // ------------------------------------------------------------
   // analog front-end drive
   // ------------------------------------------------------------
   sas_pkg::sas_afe_t afe_q;
   logic              resume_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         afe_q    <= '0;
         resume_q <= 1'b0;
      end else if (ce) begin
         afe_q.source  <= 16'h0001 << chan; // RULE1
         afe_q.sample  <= pwr & !suspend & (state_q == sas_pkg::SAS_SAMPLE); // RULE17
         afe_q.trial   <= sar_q;
         afe_q.pump    <= pwr; // RULE4
         afe_q.clk_sel <= opt_q[sas_pkg::CONV_CLOCK_SELECT_BIT]; // RULE8
         resume_q      <= !suspend; // RULE20
      end
   end

   assign afe          = afe_q;
   assign resume_ready = resume_q;
   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
endmodule // sas_core

// ==== test/sas_chk.sv ====
// concurrent checks on the converter sequencer ports
`timescale 1ns/100ps
module sas_chk (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              psel,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              stop_in,
   input wire sas_pkg::sas_afe_t afe,
   input wire logic              resume_ready
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // length of the current sample window, saturating
   logic [7:0] smp_cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n)
         smp_cnt_q <= 8'h00;
      else if (!afe.sample)
         smp_cnt_q <= 8'h00;
      else if (smp_cnt_q != 8'hff)
         smp_cnt_q <= smp_cnt_q + 8'h01;
   end
   property p_src;
      $past(rst_n, 2) |-> $onehot(afe.source);
   endproperty
   a_src: assert property (p_src) else $error("source select not one-hot");
   property p_sample;
      $fell(afe.sample) |-> smp_cnt_q >= 8'h0c;
   endproperty
   a_sample: assert property (p_sample) else $error("sample window short");
   property p_msb;
      $fell(afe.sample) |-> ##[0:3] afe.trial == 8'h80;
   endproperty
   a_msb: assert property (p_msb) else $error("first trial not msb");
   property p_ctrl_rd;
      pready && !pwrite && paddr == sas_pkg::CTRL_OFS |-> (prdata & 32'hffffff40) == 32'h0;
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read bad bits");
   property p_res_rd;
      pready && !pwrite && paddr inside {8'h04, 8'h08, 8'h0c, 8'h10} |-> prdata[31:8] == 24'h0;
   endproperty
   a_res_rd: assert property (p_res_rd) else $error("result wider than byte");
   property p_pump;
      pready && psel && pwrite && paddr == sas_pkg::OPT_OFS |-> ##2 afe.pump == $past(pwdata[7], 2);
   endproperty
   a_pump: assert property (p_pump) else $error("pump not following power bit");
   property p_conv_clock_select;
      pready && psel && pwrite && paddr == sas_pkg::OPT_OFS |-> ##2 afe.clk_sel == $past(pwdata[6], 2);
   endproperty
   a_conv_clock_select: assert property (p_conv_clock_select) else $error("clock select not following");
   property p_stop;
      stop_in [*6] |-> !resume_ready;
   endproperty
   a_stop: assert property (p_stop) else $error("ready while stopped");
endmodule // sas_chk

bind sas_core sas_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .stop_in(stop_in),
   .afe(afe), .resume_ready(resume_ready));

// ==== test/testbench.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module testbench;
   logic              clk, rst_n, ce, psel, penable, pwrite, comp_in, rc_tick;
   logic              stop_in, special_mode, pready, pslverr, resume_ready, perr;
   logic [7:0]        paddr, voff;
   logic [31:0]       pwdata, prdata, rd;
   logic [1:0]        rc_cnt;
   sas_pkg::sas_afe_t afe;
   int                errors, n_checks, n;

   sas_core dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .comp_in(comp_in), .rc_tick(rc_tick), .stop_in(stop_in),
      .special_mode(special_mode), .afe(afe), .resume_ready(resume_ready));

   // ----------------------------------------
   // analog side and bus tasks
   // ----------------------------------------
   function automatic logic [7:0] chv(input int c);
      if (c < 8) return 8'(c * 8'h1d + 8'h07);
      case (c)
         12: return 8'hff;
         13: return 8'h00;
         14: return 8'h80;
         default: return 8'h5a;
      endcase
   endfunction
   function automatic logic [7:0] vin(input logic [15:0] s);
      for (int i = 0; i < 16; i++) if (s[i]) return chv(i);
      return 8'h00;
   endfunction
   // comparator: high while the input is at or above the trial code
   assign comp_in = 8'(vin(afe.source) + voff) >= afe.trial;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      rc_cnt <= rc_cnt + 2'h1;
      rc_tick <= rc_cnt[1];
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic wait_done;
      for (int i = 0; i < 400; i++) begin
         apb(1'b0, sas_pkg::CTRL_OFS, 32'h0);
         if (rd[7] === 1'b1) break;
      end
   endtask
   task automatic res_all(input logic [31:0] e);
      for (int k = 0; k < 4; k++) rdc(8'(sas_pkg::RES1_OFS + 4 * k), e);
   endtask
   task automatic stop_try(input int lo, input int hi);
      stop_in <= 1'b1;
      repeat (8) @(posedge clk);
      stop_in <= 1'b0;
      n = 0;
      while (resume_ready !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   task automatic rst_seq;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      end_of_test;
   end
   initial begin
      {rst_n, psel, penable, pwrite, stop_in, special_mode} = 6'h00;
      {ce, rc_cnt, rc_tick, paddr, pwdata, voff} = 52'h8000000000000;
      errors = 0;
      n_checks = 0;
      rst_seq;
      rdc(sas_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, sas_pkg::RES1_OFS, 32'hff);
      rdc(sas_pkg::RES1_OFS, 32'h0);
      rdc(8'h18, 32'h0);
      chk({31'h0, perr}, 32'h1);
      apb(1'b1, sas_pkg::OPT_OFS, 32'h90);
      rdc(sas_pkg::OPT_OFS, 32'h90);
      stop_try(3998, 4012);
      $display("test registers and long stop done");
      apb(1'b1, sas_pkg::CTRL_OFS, 32'h03);
      wait_done;
      rdc(sas_pkg::CTRL_OFS, 32'h83);
      res_all(chv(3));
      repeat (60) @(posedge clk);
      chk({31'h0, afe.sample}, 32'h0);
      $display("test single channel done");
      for (int g = 0; g < 4; g++) begin
         apb(1'b1, sas_pkg::CTRL_OFS, 32'(8'h50 | g << 2 | (3 - g)));
         wait_done;
         rdc(sas_pkg::CTRL_OFS, 32'(8'h90 | g << 2 | (3 - g)));
         for (int k = 0; k < 4; k++) rdc(8'(4 + 4 * k), chv(4 * g + k));
      end
      $display("test multi channel done");
      apb(1'b1, sas_pkg::CTRL_OFS, 32'h25);
      wait_done;
      repeat (20) @(posedge clk);
      apb(1'b1, sas_pkg::CTRL_OFS, 32'h21);
      rdc(sas_pkg::CTRL_OFS, 32'h21);
      wait_done;
      res_all(chv(1));
      voff <= 8'h01;
      repeat (300) @(posedge clk);
      rdc(sas_pkg::CTRL_OFS, 32'ha1);
      res_all(chv(1) + 8'h01);
      voff <= 8'h00;
      $display("test continuous done");
      rst_seq;
      repeat (70) @(posedge clk);
      apb(1'b1, sas_pkg::OPT_OFS, 32'hd0);
      rdc(sas_pkg::OPT_OFS, 32'hc0);
      stop_try(2, 12);
      repeat (sas_pkg::BIAS_CYC) @(posedge clk);
      apb(1'b1, sas_pkg::CTRL_OFS, 32'h03);
      wait_done;
      rdc(sas_pkg::RES4_OFS, chv(3));
      special_mode <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b1, sas_pkg::OPT_OFS, 32'hd3);
      rdc(sas_pkg::OPT_OFS, 32'hd3);
      $display("test second reset done");
      end_of_test;
   end
endmodule // testbench
